// ### design/asf_top.sv
// Status flags, interrupt line and stop handling of an async serial unit.
// Assumes frame shifters and baud generator outside, on the same clock.
`timescale 1ns/100ps
`default_nettype none
module asf_top (
    input wire logic clk, // Bus clock, 10 MHz
    input wire logic resetn, // Synchronous reset, low
    input wire logic hsel, // AHB select
    input wire logic [31:0] haddr, // AHB address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write
    input wire logic [2:0] hsize, // AHB size
    input wire logic [31:0] hwdata, // AHB write data
    input wire logic hready, // AHB bus ready
    output logic [31:0] hrdata, // AHB read data
    output logic hreadyout, // AHB slave ready
    output logic hresp, // AHB response, always OKAY
    input wire logic stop_mode, // High while bus clock is gated
    input wire logic rx_pin, // Serial input pin
    input wire logic bit_tick, // Receiver bit-time pulse
    input wire logic tx_busy, // Data, preamble or break sending
    input wire logic tx_queue, // Preamble or break queued
    input wire logic tx_load, // Shifter took the data byte
    input wire logic tx_serial, // Shifter output level
    input wire logic rx_word_valid, // Received frame complete
    input wire logic [7:0] rx_word, // Received frame data
    input wire logic rx_standby_bit, // Receiver in standby
    input wire logic break_det, // Break received pulse
    input wire logic bit_mismatch, // Tx/rx mismatch pulse
    output logic tx_pin, // Serial output pin
    output logic [7:0] tx_data, // Byte for the shifter
    output logic tx_write, // Pulse: new byte queued
    output logic irq, // Interrupt request, high
    output logic stop_wake // Pulse: edge seen while stopped
);
    // ==========================================================
    // Bus slave
    asf_pkg::asf_bus_t st_r;
    logic [7:0] addr_r;
    logic wr_r;
    wire logic run = ~stop_mode;
    wire logic bus_take = hsel & htrans[1] & hready & (hsize == asf_pkg::HSIZE_WORD);
    wire logic acc = (st_r == asf_pkg::BUS_DATA);
    wire logic rd_acc = acc & ~wr_r;
    wire logic wr_acc = acc & wr_r;
    wire logic rd_main = rd_acc & (addr_r == asf_pkg::ADDR_MAIN);
    wire logic rd_data = rd_acc & (addr_r == asf_pkg::ADDR_DATA);
    wire logic wr_data = wr_acc & (addr_r == asf_pkg::ADDR_DATA);
    wire logic wr_alt = wr_acc & (addr_r == asf_pkg::ADDR_ALT);
    wire logic wr_ctrl = wr_acc & (addr_r == asf_pkg::ADDR_CTRL);

    // Address phase capture, one wait state per transfer
    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_r <= asf_pkg::BUS_IDLE;
            addr_r <= 8'h00;
            wr_r <= 1'b0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
            case (st_r)
                asf_pkg::BUS_IDLE: begin
                    if (bus_take & run) begin
                        st_r <= asf_pkg::BUS_DATA;
                        addr_r <= haddr[7:0];
                        wr_r <= hwrite;
                        hreadyout <= 1'b0;
                    end
                end
                asf_pkg::BUS_DATA: begin
                    st_r <= asf_pkg::BUS_IDLE;
                    hreadyout <= 1'b1;
                end
                default: begin
                    st_r <= asf_pkg::BUS_IDLE;
                    hreadyout <= 1'b1;
                end
            endcase
        end
    end

    // ==========================================================
    // Control and data registers
    logic [15:0] ctrl_r;
    logic [7:0] rxd_r;
    wire logic rx_pol = ctrl_r[asf_pkg::C_POL];
    wire logic berr_en = ctrl_r[asf_pkg::C_BERR_EN];
    wire logic brk_en = ctrl_r[asf_pkg::C_BRK_EN];

    // ==========================================================
    // Flags
    logic tx_data_empty_r, tc_r, rx_data_full_r, idle_r, or_r;
    logic edge_r, berr_r, brk_r;
    logic tc_cond_r, idle_blk_r;
    logic [7:0] arm_r;
    logic tx_data_empty_nxt, tc_nxt, rx_data_full_nxt, idle_nxt, or_nxt;
    logic edge_nxt, berr_nxt, brk_nxt, idle_blk_nxt;
    logic [7:0] arm_nxt;
    logic idle_hit;
    logic rx_s, rx_d_r;
    wire logic [7:0] main_byte = {tx_data_empty_r, tc_r, rx_data_full_r, idle_r, or_r, 3'h0};
    wire logic [7:0] alt_byte = {edge_r, 5'h00, berr_r, brk_r};

    // Two-step clears fire only on an armed flag; tc_r also clears on any data write
    wire logic clr_tx_data_empty = wr_data & arm_r[asf_pkg::MS_TX_DATA_EMPTY];
    wire logic clr_tc = wr_data & arm_r[asf_pkg::MS_TC];
    wire logic clr_rx_data_full = rd_data & arm_r[asf_pkg::MS_RX_DATA_FULL];
    wire logic clr_or = rd_data & arm_r[asf_pkg::MS_OR];
    wire logic clr_idle = rd_data & arm_r[asf_pkg::MS_IDLE];
    assign arm_nxt = rd_main ? main_byte :
                     rd_data ? (arm_r & asf_pkg::ARM_TX_MASK) :
                     wr_data ? (arm_r & asf_pkg::ARM_RX_MASK) : arm_r;

    // Transmit side
    wire logic tc_cond = tx_data_empty_r & ~tx_busy;
    wire logic tc_set = tc_cond & ~tc_cond_r;
    assign tx_data_empty_nxt = tx_load ? 1'b1 : (clr_tx_data_empty ? 1'b0 : tx_data_empty_r);
    assign tc_nxt = tc_set ? 1'b1 : ((clr_tc | tx_queue | wr_data) ? 1'b0 : tc_r);

    // Receive side; standby frames raise no flags
    wire logic rx_take = rx_word_valid & ~rx_standby_bit;
    wire logic rx_store = rx_take & ~rx_data_full_r;
    wire logic rx_ovr = rx_take & rx_data_full_r;
    wire logic rxd_load = rx_word_valid & ~rx_data_full_r;
    assign rx_data_full_nxt = rx_store ? 1'b1 : (clr_rx_data_full ? 1'b0 : rx_data_full_r);
    assign or_nxt = rx_ovr ? 1'b1 : (clr_or ? 1'b0 : or_r);
    wire logic idle_set = idle_hit & ~rx_standby_bit & ~idle_blk_r;
    assign idle_nxt = idle_set ? 1'b1 : (clr_idle ? 1'b0 : idle_r);
    assign idle_blk_nxt = rx_store ? 1'b0 : ((clr_idle & idle_r) ? 1'b1 : idle_blk_r);

    // Alternative flags, write one to clear
    wire logic edge_hit = rx_pol ? (rx_s & ~rx_d_r) : (~rx_s & rx_d_r);
    wire logic w1c_edge = wr_alt & hwdata[asf_pkg::AS_EDGE];
    assign edge_nxt = edge_hit ? 1'b1 : (w1c_edge ? 1'b0 : edge_r);
    assign berr_nxt = ~berr_en ? 1'b0 :
                      bit_mismatch ? 1'b1 :
                      (wr_alt & hwdata[asf_pkg::AS_BERR]) ? 1'b0 : berr_r;
    assign brk_nxt = ~brk_en ? 1'b0 :
                     break_det ? 1'b1 :
                     (wr_alt & hwdata[asf_pkg::AS_BRK]) ? 1'b0 : brk_r;

    // Interrupt sources and enables
    wire logic [7:0] main_en = {ctrl_r[asf_pkg::C_MAIN_EN_HI:asf_pkg::C_MAIN_EN_LO], 1'b1, 3'h0};
    wire logic [7:0] alt_en = ctrl_r[asf_pkg::C_ALT_EN_HI:asf_pkg::C_ALT_EN_LO] & asf_pkg::ALT_MASK;
    wire logic irq_any = (|(main_byte & main_en)) | (|(alt_byte & alt_en));

    // Read data selection
    wire logic [31:0] rd_mux = (addr_r == asf_pkg::ADDR_MAIN) ? {24'h000000, main_byte} :
                               (addr_r == asf_pkg::ADDR_ALT) ? {24'h000000, alt_byte} :
                               (addr_r == asf_pkg::ADDR_DATA) ? {24'h000000, rxd_r} :
                               (addr_r == asf_pkg::ADDR_CTRL) ? {16'h0000, ctrl_r} : 32'h00000000;

    // ==========================================================
    // Receive line helpers
    asf_sync u_sync (
        .clk(clk),
        .resetn(resetn),
        .din(rx_pin),
        .dout(rx_s)
    );

    asf_idle u_idle (
        .clk(clk),
        .resetn(resetn),
        .run(run),
        .rx_level(rx_s),
        .bit_tick(bit_tick),
        .long_word(ctrl_r[asf_pkg::C_LONG]),
        .hit(idle_hit)
    );

    // Edge detector runs even while stopped
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rx_d_r <= asf_pkg::LINE_IDLE_LVL;
            edge_r <= 1'b0;
            stop_wake <= 1'b0;
        end else begin
            rx_d_r <= rx_s;
            edge_r <= edge_nxt;
            stop_wake <= stop_mode & edge_hit;
        end
    end

    // Registers hold everything but tx_write, which clears, while stopped; reset aborts all
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctrl_r <= asf_pkg::CTRL_RST;
            rxd_r <= 8'h00;
            tx_data_empty_r <= asf_pkg::TX_DATA_EMPTY_RST;
            tc_r <= asf_pkg::TC_RST;
            tc_cond_r <= asf_pkg::TC_RST;
            rx_data_full_r <= 1'b0;
            idle_r <= 1'b0;
            or_r <= 1'b0;
            idle_blk_r <= 1'b0;
            berr_r <= 1'b0;
            brk_r <= 1'b0;
            arm_r <= 8'h00;
            hrdata <= 32'h00000000;
            tx_data <= 8'h00;
            tx_write <= 1'b0;
            tx_pin <= asf_pkg::LINE_IDLE_LVL;
            irq <= 1'b0;
        end else if (run) begin
            if (wr_ctrl) begin
                ctrl_r <= hwdata[15:0] & asf_pkg::CTRL_WMASK;
            end
            if (rxd_load) begin
                rxd_r <= rx_word;
            end
            if (rd_acc) begin
                hrdata <= rd_mux;
            end
            if (wr_data) begin
                tx_data <= hwdata[7:0];
            end
            tx_write <= wr_data;
            tx_data_empty_r <= tx_data_empty_nxt;
            tc_r <= tc_nxt;
            tc_cond_r <= tc_cond;
            rx_data_full_r <= rx_data_full_nxt;
            idle_r <= idle_nxt;
            or_r <= or_nxt;
            idle_blk_r <= idle_blk_nxt;
            berr_r <= berr_nxt;
            brk_r <= brk_nxt;
            arm_r <= arm_nxt;
            tx_pin <= tc_r ? asf_pkg::LINE_IDLE_LVL : tx_serial;
            irq <= irq_any;
        end else begin
            tx_write <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### inc/asf_pkg.sv
// Constants shared by the serial flag block and its helpers.
// Assumes a 32-bit AHB-Lite register port and an 8-bit data path.
// ==========================================================
// Register map and fields
package asf_pkg;
    // Byte offsets of the register words
    localparam logic [7:0] ADDR_MAIN = 8'h00;
    localparam logic [7:0] ADDR_ALT = 8'h04;
    localparam logic [7:0] ADDR_DATA = 8'h08;
    localparam logic [7:0] ADDR_CTRL = 8'h0c;
    // Main status bit positions
    localparam int MS_TX_DATA_EMPTY = 7;
    localparam int MS_TC = 6;
    localparam int MS_RX_DATA_FULL = 5;
    localparam int MS_IDLE = 4;
    localparam int MS_OR = 3;
    // Alternative status bit positions
    localparam int AS_EDGE = 7;
    localparam int AS_BERR = 1;
    localparam int AS_BRK = 0;
    // Control bit positions (enables sit at matching status bit, alt ones +8)
    localparam int C_LONG = 0;
    localparam int C_POL = 1;
    localparam int C_BERR_EN = 2;
    localparam int C_BRK_EN = 3;
    localparam int C_MAIN_EN_HI = 7;
    localparam int C_MAIN_EN_LO = 4;
    localparam int C_ALT_EN_HI = 15;
    localparam int C_ALT_EN_LO = 8;
    localparam logic [15:0] CTRL_WMASK = 16'h83ff;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [7:0] ALT_MASK = 8'h83;
    // Arm masks kept across the opposite data access
    localparam logic [7:0] ARM_TX_MASK = 8'hc0;
    localparam logic [7:0] ARM_RX_MASK = 8'h38;
    // Reset values
    localparam logic TX_DATA_EMPTY_RST = 1'b1;
    localparam logic TC_RST = 1'b1;
    localparam logic LINE_IDLE_LVL = 1'b1;
    // Idle character lengths in bit times
    localparam logic [3:0] IDLE_BITS_SHORT = 4'ha;
    localparam logic [3:0] IDLE_BITS_LONG = 4'hb;
    // AHB encodings
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    // Bus slave states
    typedef enum logic {BUS_IDLE = 1'b0, BUS_DATA = 1'b1} asf_bus_t;
endpackage

// ### design/asf_sync.sv
// Two-flop synchroniser for the serial input pin.
// Assumes the pin is asynchronous to clk and idles high.
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Synchroniser
module asf_sync (
    input wire logic clk, // Bus clock
    input wire logic resetn, // Synchronous reset, low
    input wire logic din, // Asynchronous level
    output logic dout // Synchronised level
);
    logic meta_r;
    // First flop feeds only the second
    always_ff @(posedge clk) begin
        if (!resetn) begin
            meta_r <= asf_pkg::LINE_IDLE_LVL;
            dout <= asf_pkg::LINE_IDLE_LVL;
        end else begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule
`default_nettype wire

// ### design/asf_idle.sv
// Counts consecutive high bit times on the receive line.
// Assumes bit_tick pulses once per bit time on clk.
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Idle character detector
module asf_idle (
    input wire logic clk, // Bus clock
    input wire logic resetn, // Synchronous reset, low
    input wire logic run, // Low while stopped
    input wire logic rx_level, // Synchronised line level
    input wire logic bit_tick, // One pulse per bit time
    input wire logic long_word, // Word-length select
    output logic hit // Pulse on idle reached
);
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    wire logic [3:0] limit = long_word ? asf_pkg::IDLE_BITS_LONG : asf_pkg::IDLE_BITS_SHORT;
    wire logic step = run & bit_tick;
    wire logic at_last = rx_level & (cnt_r == limit - 4'h1);
    // Count saturates at limit until a low bit restarts it
    assign cnt_nxt = !rx_level ? 4'h0 : (cnt_r == limit) ? cnt_r : cnt_r + 4'h1;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cnt_r <= 4'h0;
            hit <= 1'b0;
        end else begin
            hit <= step & at_last;
            if (step) begin
                cnt_r <= cnt_nxt;
            end
        end
    end
endmodule
`default_nettype wire

// ### verification/asf_top_properties.sv
// Port-level checker for the serial flag block.
// Assumes asf_top ports on one clock, bound below.
`timescale 1ns/100ps
`default_nettype none
// ==========================
// Checker
module asf_props (
    input wire logic clk, // Clock
    input wire logic resetn, // Reset, low
    input wire logic hsel, // Select
    input wire logic [31:0] haddr, // Address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write
    input wire logic [2:0] hsize, // Size
    input wire logic hready, // Bus ready
    input wire logic [31:0] hrdata, // Read data
    input wire logic hreadyout, // Slave ready
    input wire logic hresp, // Response
    input wire logic stop_mode, // Stop
    input wire logic tx_serial, // Shifter level
    input wire logic tx_pin, // Serial out
    input wire logic [7:0] tx_data, // Byte out
    input wire logic tx_write, // Byte pulse
    input wire logic irq, // Interrupt
    input wire logic stop_wake // Wake pulse
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    wire take;
    wire wr_data;
    // Accepted transfer and data register write
    assign take = hsel && htrans[1] && hready && (hsize == asf_pkg::HSIZE_WORD) && !stop_mode;
    assign wr_data = take && hwrite && (haddr[7:0] == asf_pkg::ADDR_DATA);
    reset_state_a: assert property (disable iff (1'b0)
        !resetn |=> hreadyout && !hresp && tx_pin && !irq && !tx_write && !stop_wake && (hrdata == 32'h0))
        else $error("outputs not at reset values");
    resp_okay_a: assert property (hresp == 1'b0)
        else $error("response not okay");
    bus_wait_a: assert property (take && hreadyout |=> !hreadyout ##1 hreadyout)
        else $error("wait state wrong");
    stop_ignore_a: assert property (hsel && htrans[1] && hready && stop_mode |=> hreadyout)
        else $error("transfer taken while stopped");
    stop_hold_a: assert property (stop_mode [*3] |-> $stable(hrdata) && $stable(tx_data) && !tx_write)
        else $error("state changed while stopped");
    stop_wake_a: assert property (stop_wake |-> $past(stop_mode) ##1 !stop_wake)
        else $error("wake pulse wrong");
    tx_write_a: assert property (wr_data |-> ##[2:3] tx_write ##1 !tx_write)
        else $error("byte pulse missing");
    tx_idle_a: assert property (!tx_pin |-> !$past(tx_serial) || !$past(tx_serial, 2))
        else $error("serial out low while shifter idle");
    cover property (stop_wake);
    cover property (wr_data ##[2:3] tx_write);
    cover property ($rose(irq));
endmodule
bind asf_top asf_props u_props (
    .clk(clk),
    .resetn(resetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .stop_mode(stop_mode),
    .tx_serial(tx_serial),
    .tx_pin(tx_pin),
    .tx_data(tx_data),
    .tx_write(tx_write),
    .irq(irq),
    .stop_wake(stop_wake)
);
`default_nettype wire

// ### verification/asf_node.sv
// Shifter side and remote node driving the serial flag block.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/100ps
`default_nettype none
// ==========================
// Partner model
module asf_node (
    input wire logic clk, // Clock
    output logic rx_pin, // Line level
    output logic bit_tick, // Bit time pulse
    output logic rx_word_valid, // Frame done
    output logic [7:0] rx_word, // Frame data
    output logic break_det, // Break pulse
    output logic bit_mismatch, // Mismatch pulse
    output logic tx_queue, // Queue pulse
    output logic tx_load, // Load pulse
    output logic tx_busy, // Shifting
    output logic tx_serial // Shifter level
);
    // Line idles high, shifter idle
    initial begin
        {rx_pin, tx_serial, bit_tick, rx_word_valid, break_det, bit_mismatch, tx_queue, tx_load, tx_busy, rx_word} = {2'h3, 15'h0};
    end
    // One frame; data lines scrambled once it is gone
    task frame(input logic [7:0] d);
        @(posedge clk);
        {rx_word_valid, rx_word} <= {1'b1, d};
        @(posedge clk);
        {rx_word_valid, rx_word} <= {1'b0, ~d};
    endtask
    // Bit times of the current line level
    task ticks(input int n);
        repeat (n) begin
            @(posedge clk);
            bit_tick <= 1'b1;
            @(posedge clk);
            bit_tick <= 1'b0;
        end
    endtask
    // Line change, then time to pass the synchroniser
    task pin(input logic v);
        @(posedge clk);
        rx_pin <= v;
        repeat (4) @(posedge clk);
    endtask
    // Pulse: 0 break, 1 mismatch, 2 queue
    task ev(input int k);
        @(posedge clk);
        {tx_queue, bit_mismatch, break_det} <= 3'h1 << k;
        @(posedge clk);
        {tx_queue, bit_mismatch, break_det} <= 3'h0;
    endtask
    // Shifter takes the byte, or finishes it
    task load(input logic go);
        @(posedge clk);
        {tx_load, tx_busy, tx_serial} <= {go, go, ~go};
        @(posedge clk);
        tx_load <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ### verification/tb.sv
// Self-checking bench for the serial flag block.
// Assumes asf_top, asf_node and the checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
// ==========================
// Bench
module tb;
    localparam logic [7:0] A_M = asf_pkg::ADDR_MAIN;
    localparam logic [7:0] A_A = asf_pkg::ADDR_ALT;
    localparam logic [7:0] A_D = asf_pkg::ADDR_DATA;
    localparam logic [7:0] A_C = asf_pkg::ADDR_CTRL;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic stop_mode = 1'b0;
    logic standby = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = asf_pkg::HSIZE_WORD;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, q;
    logic hreadyout, hresp, tx_pin, tx_write, irq, stop_wake;
    logic rx_pin, bit_tick, rx_word_valid, break_det, bit_mismatch, tx_queue, tx_load, tx_busy, tx_serial;
    logic [7:0] tx_data, rx_word;
    int n_fail = 0, n_checks = 0, cyc = 0, n_wake = 0;
    asf_top uut (
        .clk(clk),
        .resetn(resetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hreadyout),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .stop_mode(stop_mode),
        .rx_pin(rx_pin),
        .bit_tick(bit_tick),
        .tx_busy(tx_busy),
        .tx_queue(tx_queue),
        .tx_load(tx_load),
        .tx_serial(tx_serial),
        .rx_word_valid(rx_word_valid),
        .rx_word(rx_word),
        .rx_standby_bit(standby),
        .break_det(break_det),
        .bit_mismatch(bit_mismatch),
        .tx_pin(tx_pin),
        .tx_data(tx_data),
        .tx_write(tx_write),
        .irq(irq),
        .stop_wake(stop_wake)
    );
    asf_node node (
        .clk(clk),
        .rx_pin(rx_pin),
        .bit_tick(bit_tick),
        .rx_word_valid(rx_word_valid),
        .rx_word(rx_word),
        .break_det(break_det),
        .bit_mismatch(bit_mismatch),
        .tx_queue(tx_queue),
        .tx_load(tx_load),
        .tx_busy(tx_busy),
        .tx_serial(tx_serial)
    );
    always #50 clk = ~clk;
    // Hang limit and wake pulse count
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (stop_wake === 1'b1) n_wake++;
        if (cyc == 20000) begin
            n_fail++;
            wrap_up();
        end
    end
    // Single word transfer; read data taken at the ready edge
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {hsel, hwrite, htrans, haddr} <= {1'b1, w, 2'h2, 24'h0, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        {hsel, htrans, hwdata} <= {3'h0, d};
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    task wrap_up();
        if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        rd(A_M, 32'hc0);
        rd(A_A, 32'h0);
        rd(8'h10, 32'h0);
        bus(1'b1, A_C, 32'hffffffff);
        rd(A_C, 32'h83ff);
        bus(1'b1, A_C, 32'h80);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, A_D, 32'h5a);
        chk({24'h0, tx_data}, 32'h5a);
        rd(A_M, 32'h0);
        chk({31'h0, irq}, 32'h0);
        node.load(1'b1);
        rd(A_M, 32'h80);
        node.load(1'b0);
        rd(A_M, 32'hc0);
        chk({31'h0, tx_pin}, 32'h1);
        node.ev(2);
        bus(1'b1, A_C, 32'h0);
        rd(A_M, 32'h80);
        node.frame(8'h3c);
        rd(A_M, 32'ha0);
        node.frame(8'h99);
        rd(A_M, 32'ha8);
        chk({31'h0, irq}, 32'h1);
        rd(A_D, 32'h3c);
        rd(A_M, 32'h80);
        for (int p = 0; p < 2; p++) begin
            bus(1'b1, A_C, 32'(p << 1));
            bus(1'b1, A_A, 32'h80);
            node.pin(1'b0);
            rd(A_A, p ? 32'h0 : 32'h80);
            node.pin(1'b1);
            rd(A_A, 32'h80);
            bus(1'b1, A_A, 32'h80);
            rd(A_A, 32'h0);
        end
        for (int m = 0; m < 2; m++) begin
            bus(1'b1, A_C, 32'(m));
            node.pin(1'b0);
            node.ticks(1);
            node.pin(1'b1);
            node.frame(8'h11);
            rd(A_M, 32'ha0);
            rd(A_D, 32'h11);
            node.ticks(9 + m);
            rd(A_M, 32'h80);
            node.ticks(1);
            rd(A_M, 32'h90);
            rd(A_D, 32'h11);
            rd(A_M, 32'h80);
            node.ticks(12);
            rd(A_M, 32'h80);
        end
        bus(1'b1, A_C, 32'h030c);
        bus(1'b1, A_A, 32'hff);
        node.ev(0);
        node.ev(1);
        rd(A_A, 32'h3);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, A_A, 32'h1);
        rd(A_A, 32'h2);
        node.ev(0);
        bus(1'b1, A_C, 32'h0300);
        rd(A_A, 32'h0);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, A_C, 32'h8000);
        @(posedge clk);
        stop_mode <= 1'b1;
        bus(1'b1, A_C, 32'h0);
        node.pin(1'b0);
        node.pin(1'b1);
        chk(n_wake, 32'h1);
        @(posedge clk);
        stop_mode <= 1'b0;
        rd(A_C, 32'h8000);
        rd(A_A, 32'h80);
        chk({31'h0, irq}, 32'h1);
        @(posedge clk);
        {stop_mode, resetn} <= 2'h2;
        repeat (2) @(posedge clk);
        stop_mode <= 1'b0;
        @(posedge clk);
        resetn <= 1'b1;
        rd(A_M, 32'hc0);
        rd(A_C, 32'h0);
        standby <= 1'b1;
        node.frame(8'h77);
        rd(A_M, 32'hc0);
        wrap_up();
    end
endmodule
`default_nettype wire
